// file: logic/amh_alert_gate.sv
`timescale 1ns/100ps
// ****************************************
// per-event mask gating
// ****************************************
module amh_alert_gate #(
  parameter int N = 6
) (
  input wire logic [N-1:0] event_in,
  input wire logic [N-1:0] mask_in,
  output logic any_out
);
  logic [N-1:0] pass;
  // one gate per event source
  for (genvar i = 0; i < N; i++) begin : g_ev
    assign pass[i] = event_in[i] & ~mask_in[i];
  end
  assign any_out = |pass;
endmodule

// file: logic/amh_pkg.sv
package amh_pkg;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_ALERT_MASK = 8'hea;
  localparam logic [7:0] CMD_HYS_SELECT = 8'heb;
  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int BIT_TEMP_WARN = 0;
  localparam int BIT_INPUT_HIGH = 1;
  localparam int BIT_OVERCURRENT = 2;
  localparam int BIT_INPUT_LOW = 3;
  localparam int BIT_TEMP_FAULT = 4;
  localparam int BIT_LOCKOUT = 5;
  localparam int NUM_EVENTS = 6;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [1:0] HYS_RESET = 2'h0;
  // ****************************************
  // hysteresis codes and degrees
  // ****************************************
  localparam logic [1:0] HYS_CODE_20 = 2'h0;
  localparam logic [1:0] HYS_CODE_25 = 2'h1;
  localparam logic [1:0] HYS_CODE_30 = 2'h2;
  localparam logic [1:0] HYS_CODE_35 = 2'h3;
  localparam logic [7:0] HYS_DEG_20 = 8'h14;
  localparam logic [7:0] HYS_DEG_25 = 8'h19;
  localparam logic [7:0] HYS_DEG_30 = 8'h1e;
  localparam logic [7:0] HYS_DEG_35 = 8'h23;
endpackage

// file: logic/amh_top.sv
`timescale 1ns/100ps
// What this block does
// - mask bit 5 set stops input lockout from driving alert; clear lets it.
// - mask bit 4 set stops temperature fault raising alert; clear lets it.
// - mask bit 3 set stops input low warning raising alert.
// - mask bit 2 set stops input overcurrent warning raising alert.
// - mask bit 1 set stops input high warning raising alert.
// - mask bit 0 set stops temperature warning raising alert.
// - read/write 2-bit hysteresis register at command code ebh.
// - hysteresis code 00 gives 20 degrees, code 11 gives 35 degrees.
module amh_top (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] cmd_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [amh_pkg::NUM_EVENTS-1:0] event_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  output logic rd_err_out,
  output logic alert_out_n,
  output logic [1:0] hysteresis_code_out,
  output logic [7:0] hys_degrees_out
);
  import amh_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [5:0] mask_q;
  logic [1:0] hys_q;
  logic any_alert;
  logic [7:0] deg_d;

  // alert mask write, upper bits not held here
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mask_q <= MASK_RESET;
    end else if (wr_en_in && cmd_in == CMD_ALERT_MASK) begin
      mask_q <= wr_data_in[5:0];
    end
  end

  // hysteresis write, reserved bits dropped
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hys_q <= HYS_RESET;
    end else if (wr_en_in && cmd_in == CMD_HYS_SELECT) begin
      hys_q <= wr_data_in[1:0];
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rd_data_out <= 16'h0000;
      rd_valid_out <= 1'b0;
      rd_err_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      rd_err_out <= 1'b0;
      rd_data_out <= 16'h0000;
      if (rd_en_in) begin
        case (cmd_in)
          CMD_ALERT_MASK: rd_data_out <= {10'h000, mask_q};
          CMD_HYS_SELECT: rd_data_out <= {14'h0000, hys_q};
          default: rd_err_out <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************
  // alert gating
  // ****************************************
  // bits 0..5 mask each event source
  amh_alert_gate #(.N(NUM_EVENTS)) u_gate (
    .event_in(event_in),
    .mask_in(mask_q),
    .any_out(any_alert)
  );

  // active-low alert, registered
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      alert_out_n <= 1'b1;
    end else begin
      alert_out_n <= ~any_alert;
    end
  end

  // ****************************************
  // hysteresis decode
  // ****************************************
  always_comb begin
    case (hys_q)
      HYS_CODE_20: deg_d = HYS_DEG_20;
      HYS_CODE_25: deg_d = HYS_DEG_25;
      HYS_CODE_30: deg_d = HYS_DEG_30;
      HYS_CODE_35: deg_d = HYS_DEG_35;
      default: deg_d = HYS_DEG_20;
    endcase
  end

  // selected hysteresis to protection path
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hysteresis_code_out <= HYS_RESET;
      hys_degrees_out <= HYS_DEG_20;
    end else begin
      hysteresis_code_out <= hys_q;
      hys_degrees_out <= deg_d;
    end
  end
endmodule

// file: tb/amh_host.sv
`timescale 1ns/100ps
// host that issues one register command at a time
module amh_host (
  input wire logic clk_in,
  output logic wr_en_out, rd_en_out,
  output logic [7:0] cmd_out,
  output logic [15:0] data_out
);
  initial {wr_en_out, rd_en_out, cmd_out, data_out} = 26'h0;
  // one strobe cycle, then data falls to its inverse
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_in);
    {wr_en_out, rd_en_out, cmd_out, data_out} = {w, !w, c, d};
    @(negedge clk_in);
    {wr_en_out, rd_en_out, data_out} = {2'h0, ~d};
  endtask
endmodule

// file: tb/amh_top_sva.sv
`timescale 1ns/100ps
module amh_top_sva (
  input wire logic clk_in, srst_in, wr_en_in, rd_en_in, rd_valid_out, rd_err_out, alert_out_n,
  input wire logic [7:0] cmd_in, hys_degrees_out,
  input wire logic [15:0] wr_data_in, rd_data_out,
  input wire logic [amh_pkg::NUM_EVENTS-1:0] event_in,
  input wire logic [1:0] hysteresis_code_out
);
  import amh_pkg::*;
  logic [5:0] m_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // shadow of the mask register
  always_ff @(posedge clk_in) begin
    if (srst_in) m_q <= MASK_RESET;
    else if (wr_en_in && cmd_in == CMD_ALERT_MASK) m_q <= wr_data_in[5:0];
  end
  sequence s_rd(c); rd_en_in && cmd_in == c; endsequence
  property p_up; |(event_in & ~m_q) |=> !alert_out_n; endproperty
  a_up: assert property (p_up) else $error("alert missing");
  property p_off; !(|(event_in & ~m_q)) |=> alert_out_n; endproperty
  a_off: assert property (p_off) else $error("alert not masked");
  property p_vld; rd_en_in |=> rd_valid_out; endproperty
  a_vld: assert property (p_vld) else $error("no read valid");
  property p_hys; s_rd(CMD_HYS_SELECT) |=> rd_data_out == {14'h0, hysteresis_code_out}; endproperty
  a_hys: assert property (p_hys) else $error("bad level read");
  property p_mrd; s_rd(CMD_ALERT_MASK) |=> rd_data_out == {10'h0, $past(m_q)}; endproperty
  a_mrd: assert property (p_mrd) else $error("bad mask read");
  property p_err; s_rd(8'h00) |=> rd_err_out && rd_data_out == 16'h0; endproperty
  a_err: assert property (p_err) else $error("no read error");
  property p_deg; hys_degrees_out == 8'h14 + 8'h05 * hysteresis_code_out; endproperty
  a_deg: assert property (p_deg) else $error("bad degrees");
  // a hysteresis write not overtaken by another one in the next cycle
  sequence s_wr_once;
    wr_en_in && cmd_in == CMD_HYS_SELECT ##1 !(wr_en_in && cmd_in == CMD_HYS_SELECT);
  endsequence
  property p_wr; s_wr_once |=> hysteresis_code_out == $past(wr_data_in[1:0], 2); endproperty
  a_wr: assert property (p_wr) else $error("level not taken");
endmodule
bind amh_top amh_top_sva u_sva (.clk_in, .srst_in, .wr_en_in, .rd_en_in, .rd_valid_out, .rd_err_out,
  .alert_out_n, .cmd_in, .hys_degrees_out, .wr_data_in, .rd_data_out, .event_in, .hysteresis_code_out);

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import amh_pkg::*;
  logic clk_in = 1'b0, srst_in = 1'b1, wr, rd, vld, err, al_n;
  logic [5:0] ev = 6'h0;
  logic [7:0] cmd, deg;
  logic [15:0] wd, rdat;
  logic [1:0] code;
  int mismatches = 0, compares = 0;
  initial forever #2.5 clk_in = ~clk_in;
  amh_host u_amh_host (.clk_in, .wr_en_out(wr), .rd_en_out(rd), .cmd_out(cmd), .data_out(wd));
  amh_top u_amh_top (.clk_in, .srst_in, .wr_en_in(wr), .rd_en_in(rd), .cmd_in(cmd), .wr_data_in(wd),
    .event_in(ev), .rd_data_out(rdat), .rd_valid_out(vld), .rd_err_out(err), .alert_out_n(al_n),
    .hysteresis_code_out(code), .hys_degrees_out(deg));
  task automatic chk(string n, logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // reset values, every level code, unmapped read
  task automatic t_reg();
    u_amh_host.xfer(1'b0, CMD_ALERT_MASK, 16'h0);
    chk("mask", 16'h0, rdat);
    chk("valid", 16'h1, vld);
    for (int c = 0; c < 4; c++) begin
      u_amh_host.xfer(1'b0, CMD_HYS_SELECT, 16'h0);
      chk("level", 16'(c), rdat);
      chk("code", 16'(c), code);
      chk("deg", 16'(c * 5 + 20), deg);
      u_amh_host.xfer(1'b1, CMD_HYS_SELECT, 16'((c + 1) & 3));
    end
    u_amh_host.xfer(1'b0, 8'h00, 16'h0);
    chk("err", 16'h1, err);
    chk("errdata", 16'h0, rdat);
  endtask
  // each event alone, masked then open
  task automatic t_mask();
    for (int k = 0; k < 6; k++) begin
      ev = 6'h1 << k;
      u_amh_host.xfer(1'b1, CMD_ALERT_MASK, 16'h1 << k);
      @(negedge clk_in);
      chk("masked", 16'h1, al_n);
      u_amh_host.xfer(1'b1, CMD_ALERT_MASK, 16'h3f ^ (16'h1 << k));
      @(negedge clk_in);
      chk("open", 16'h0, al_n);
    end
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    srst_in = 1'b0;
    t_reg();
    t_mask();
    wrap_up();
  end
endmodule
